// File: logic/pac_defines.svh
// Timing counts, field codes and fixed values for the PMIC control block
`ifndef PAC_DEFINES_SVH
`define PAC_DEFINES_SVH

`define PAC_CLK_MHZ          100
`define PAC_POR_DELAY_MS     100
`define PAC_POR_DELAY_CYCLES (`PAC_POR_DELAY_MS * 1000 * `PAC_CLK_MHZ)
`define PAC_RST_STEP_MS      10
`define PAC_RST_STEP_CYCLES  (`PAC_RST_STEP_MS * 1000 * `PAC_CLK_MHZ)
`define PAC_LONG_PRESS_MS    1000
`define PAC_LONG_CYCLES      (`PAC_LONG_PRESS_MS * 1000 * `PAC_CLK_MHZ)

`define PAC_STEP_MV          13'h0032
`define PAC_LDO_BASE_MV      13'h01f4
`define PAC_LDO_MAX_MV       13'h0e42
`define PAC_SW_BASE_MV       13'h03e8

`define PAC_SEQ_HOST         3'h0
`define PAC_SEQ_PT0          3'h1
`define PAC_SEQ_PT1          3'h2
`define PAC_SEQ_PT2          3'h3
`define PAC_SEQ_PT3          3'h4
`define PAC_SEQ_CTL_LOW      3'h5
`define PAC_SEQ_CTL_HIGH     3'h6
`define PAC_SEQ_HOST_ALT     3'h7

`define PAC_PULL_BATTERY_NEGATIVE_RAIL_BIT    0
`define PAC_PULL_GND_BIT     1
`define PAC_DRIVE_LVL_BIT    0
`define PAC_DRIVE_CTL_BIT    1

`define PAC_MON_BAT          3'h4
`define PAC_MON_WIDTH        5
`define PAC_PWR_WAKE_ONLY    2'h0

`endif

// File: logic/pac_pkg.sv
// Types shared by the PMIC control block
package pac_pkg;

	typedef enum logic [2:0] {
		PAC_OFF = 3'b001,
		PAC_SEQ = 3'b010,
		PAC_ON  = 3'b100
	} pac_state_type;

	typedef logic [2:0]  pac_seq_type;
	typedef logic [12:0] pac_mv_type;
	typedef logic [5:0]  pac_code_type;

endpackage

// File: logic/pac_aux_drive.sv
// Level decoder of the auxiliary level-shifted output
`timescale 1ns/1ps
`include "pac_defines.svh"

module pac_aux_drive (
	// Configuration
	input  wire logic [1:0] pull_mode_in,
	input  wire logic [1:0] drive_select_in,
	input  wire logic       ctl_capable_in,
	// Synchronised control input
	input  wire logic       ctl_in,
	// Decoded drive
	output logic            level_out,
	output logic            oe_out
);
	logic want_gnd;

	always_comb begin
		if (ctl_capable_in && drive_select_in[`PAC_DRIVE_CTL_BIT]) begin
			// Follow or invert the control input
			want_gnd = ctl_in ^ drive_select_in[`PAC_DRIVE_LVL_BIT];
		end else begin
			// Register control: 0 toward ground, 1 toward battery rail
			want_gnd = ~drive_select_in[`PAC_DRIVE_LVL_BIT];
		end
		// Disallowed direction leaves the pin floating
		if (want_gnd) begin
			oe_out = pull_mode_in[`PAC_PULL_GND_BIT];
		end else begin
			oe_out = pull_mode_in[`PAC_PULL_BATTERY_NEGATIVE_RAIL_BIT];
		end
		level_out = want_gnd;
	end

endmodule // pac_aux_drive

// File: logic/pac_ctrl.sv
// Digital control of the PMIC: wake, sequencing, enables and aux output
`timescale 1ns/1ps
`include "pac_defines.svh"

module pac_ctrl #(
	parameter logic [31:0] POR_DELAY_CYCLES  = `PAC_POR_DELAY_CYCLES,
	parameter logic [31:0] RST_STEP_CYCLES   = `PAC_RST_STEP_CYCLES,
	parameter logic [31:0] LONG_PRESS_CYCLES = `PAC_LONG_CYCLES
) (
	// Clock and reset
	input  wire logic               clk_in,
	input  wire logic               nrst_in,
	// Pins
	input  wire logic               button_input_n_in,
	input  wire logic               aux_control_input_in,
	// Aux output configuration
	input  wire logic [1:0]         aux_pull_mode_in,
	input  wire logic [1:0]         aux_drive_select_in,
	// Factory sequence codes, two per field, regulator 0 in low bits
	input  wire logic [5:0]         switcher_sequence_select_in,
	input  wire logic [5:0]         linear_sequence_select_in,
	// Host control, set by the bus engine at its own addresses
	input  wire logic [1:0]         switcher_host_enable_in,
	input  wire logic [1:0]         linear_host_enable_in,
	input  wire logic [3:0]         discharge_select_in,
	input  wire logic [1:0]         reset_delay_select_in,
	input  wire logic [1:0]         power_config_in,
	input  wire logic               host_shutdown_in,
	input  wire logic [2:0]         monitor_select_in,
	// Voltage codes
	input  wire pac_pkg::pac_code_type sw0_code_in,
	input  wire pac_pkg::pac_code_type sw1_code_in,
	input  wire pac_pkg::pac_code_type ldo0_code_in,
	input  wire pac_pkg::pac_code_type ldo1_code_in,
	// Regulator control
	output logic [1:0]              switcher_enable_out,
	output logic [1:0]              linear_enable_out,
	output logic [3:0]              discharge_out,
	output pac_pkg::pac_mv_type     sw0_target_mv_out,
	output pac_pkg::pac_mv_type     sw1_target_mv_out,
	output pac_pkg::pac_mv_type     ldo0_target_mv_out,
	output pac_pkg::pac_mv_type     ldo1_target_mv_out,
	output logic [4:0]              monitor_output_out,
	// Aux output pin
	output logic                    aux_level_output_out,
	output logic                    aux_level_output_oe_out,
	// Open-drain pins
	output logic                    button_status_out_n_out,
	output logic                    button_status_oe_out,
	output logic                    reset_out_n_out,
	output logic                    reset_oe_out,
	// Status
	output logic                    awake_out,
	output logic                    long_press_out,
	output logic                    short_press_out
);
	import pac_pkg::*;

	function automatic pac_mv_type code_to_mv(input pac_mv_type base,
		input pac_code_type code);
		code_to_mv = base + pac_mv_type'(code) * `PAC_STEP_MV;
	endfunction

	function automatic logic ctl_code(input pac_seq_type code);
		ctl_code = (code == `PAC_SEQ_CTL_LOW) || (code == `PAC_SEQ_CTL_HIGH);
	endfunction

	function automatic logic reg_request(input pac_seq_type code,
		input logic host, input logic ctl, input logic [3:0] hit,
		input logic on);
		case (code)
			`PAC_SEQ_PT0: reg_request = hit[0];
			`PAC_SEQ_PT1: reg_request = hit[1];
			`PAC_SEQ_PT2: reg_request = hit[2];
			`PAC_SEQ_PT3: reg_request = hit[3];
			`PAC_SEQ_CTL_LOW: reg_request = on & ~ctl;
			`PAC_SEQ_CTL_HIGH: reg_request = on & ctl;
			default: reg_request = on & host;
		endcase
	endfunction

	// Synchronisers
	logic [1:0] btn_sync;
	logic [1:0] ctl_sync;
	logic [1:0] next_btn_sync;
	logic [1:0] next_ctl_sync;

	// Control state
	pac_state_type state;
	pac_state_type next_state;
	logic [31:0]   timer;
	logic [31:0]   next_timer;
	logic [31:0]   press_cnt;
	logic [31:0]   next_press_cnt;
	logic          armed;
	logic          next_armed;
	logic          btn_prev;
	logic          next_btn_prev;

	// Registered outputs
	logic [1:0] next_sw_en;
	logic [1:0] next_ldo_en;
	logic [3:0] next_discharge;
	logic [4:0] next_monitor;
	pac_mv_type next_sw0_mv;
	pac_mv_type next_sw1_mv;
	pac_mv_type next_ldo0_mv;
	pac_mv_type next_ldo1_mv;
	logic       next_aux_level;
	logic       next_aux_oe;
	logic       next_btn_oe;
	logic       next_rst_oe;
	logic       next_long;
	logic       next_short;

	// Decoded
	logic        pressed;
	logic        ctl;
	logic        ctl_capable;
	logic        on;
	logic [3:0]  hit;
	logic [31:0] third;
	logic [31:0] pt [4];
	logic        aux_level;
	logic        aux_oe;

	// Button low means active; open pin is pulled inactive
	assign pressed = ~btn_sync[1];
	assign ctl     = ctl_sync[1];
	assign on      = (state == PAC_ON);

	// Input-controlled part when any sequence field holds 101 or 110
	assign ctl_capable = ctl_code(switcher_sequence_select_in[2:0]) |
		ctl_code(switcher_sequence_select_in[5:3]) |
		ctl_code(linear_sequence_select_in[2:0]) |
		ctl_code(linear_sequence_select_in[5:3]);

	pac_aux_drive u_aux (
		.pull_mode_in    (aux_pull_mode_in),
		.drive_select_in (aux_drive_select_in),
		.ctl_capable_in  (ctl_capable),
		.ctl_in          (ctl),
		.level_out       (aux_level),
		.oe_out          (aux_oe)
	);

	// Two-stage synchronisers
	always_comb begin
		next_btn_sync = {btn_sync[0], button_input_n_in};
		next_ctl_sync = {ctl_sync[0], aux_control_input_in};
	end

	// Enable points: fixed delay, then thirds of the reset delay
	always_comb begin
		third = RST_STEP_CYCLES * (32'h1 + 32'(reset_delay_select_in));
		pt[0] = POR_DELAY_CYCLES;
		pt[1] = POR_DELAY_CYCLES + third;
		pt[2] = POR_DELAY_CYCLES + third + third;
		pt[3] = POR_DELAY_CYCLES + third + third + third;
		for (int i = 0; i < 4; i++) begin
			hit[i] = (state != PAC_OFF) && (timer >= pt[i]);
		end
	end

	// Power state, timer and button classification
	always_comb begin
		next_state     = state;
		next_timer     = timer;
		next_press_cnt = press_cnt;
		next_armed     = armed;
		next_btn_prev  = pressed;
		next_long      = 1'b0;
		next_short     = 1'b0;
		case (state)
			PAC_OFF: begin
				next_timer = 32'h0;
				next_armed = 1'b0;
				// Any press wakes, power config is not consulted
				if (pressed) begin
					next_state = PAC_SEQ;
				end
			end
			PAC_SEQ: begin
				next_timer = timer + 32'h1;
				if (timer >= pt[3]) begin
					next_state = PAC_ON;
				end
			end
			PAC_ON: begin
				// The waking press is never classed, or it could shut down
				if (pressed && !btn_prev) begin
					next_armed     = 1'b1;
					next_press_cnt = 32'h0;
				end else if (pressed && press_cnt != 32'hffffffff) begin
					next_press_cnt = press_cnt + 32'h1;
				end
				if (!pressed && btn_prev && armed) begin
					next_armed = 1'b0;
					// Long or short by held time
					if (press_cnt >= LONG_PRESS_CYCLES) begin
						next_long = 1'b1;
						if (power_config_in != `PAC_PWR_WAKE_ONLY) begin
							next_state = PAC_OFF;
						end
					end else begin
						next_short = 1'b1;
					end
				end
				if (host_shutdown_in) begin
					next_state = PAC_OFF;
				end
			end
			default: begin
				next_state = PAC_OFF;
			end
		endcase
	end

	// Regulator enables and discharge
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// Sequencer point, control input or host command, per factory code
			next_sw_en[i] = (state != PAC_OFF) && reg_request(
				switcher_sequence_select_in[3*i +: 3],
				switcher_host_enable_in[i], ctl, hit, on);
			// Switcher must be running now and stay on next cycle
			next_ldo_en[i] = next_sw_en[i] && switcher_enable_out[i] &&
				reg_request(linear_sequence_select_in[3*i +: 3],
				linear_host_enable_in[i], ctl, hit, on);
		end
		// Off regulators discharge as selected
		next_discharge = ~{next_ldo_en, next_sw_en} & discharge_select_in;
	end

	// Voltage targets, monitor select and pins
	always_comb begin
		// Independent switcher targets
		next_sw0_mv  = code_to_mv(`PAC_SW_BASE_MV, sw0_code_in);
		next_sw1_mv  = code_to_mv(`PAC_SW_BASE_MV, sw1_code_in);
		// Full six-bit code reaches exactly the top of the range
		next_ldo0_mv = code_to_mv(`PAC_LDO_BASE_MV, ldo0_code_in);
		next_ldo1_mv = code_to_mv(`PAC_LDO_BASE_MV, ldo1_code_in);
		// One-hot, codes above the battery channel also pick it
		next_monitor = 5'h00;
		if (monitor_select_in >= `PAC_MON_BAT) begin
			next_monitor[4] = 1'b1;
		end else begin
			next_monitor[monitor_select_in[1:0]] = 1'b1;
		end
		// Aux pin floats while off
		next_aux_level = aux_level;
		next_aux_oe    = (state != PAC_OFF) && aux_oe;
		// Pull status low while the button is held
		next_btn_oe    = pressed;
		// Hold reset low until sequencing completes
		next_rst_oe    = (next_state != PAC_ON);
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			btn_sync                <= 2'h3;
			ctl_sync                <= 2'h0;
			state                   <= PAC_OFF;
			timer                   <= 32'h0;
			press_cnt               <= 32'h0;
			armed                   <= 1'b0;
			btn_prev                <= 1'b0;
			switcher_enable_out     <= 2'h0;
			linear_enable_out       <= 2'h0;
			discharge_out           <= 4'h0;
			sw0_target_mv_out       <= 13'h0000;
			sw1_target_mv_out       <= 13'h0000;
			ldo0_target_mv_out      <= 13'h0000;
			ldo1_target_mv_out      <= 13'h0000;
			monitor_output_out      <= 5'h00;
			aux_level_output_out    <= 1'b0;
			aux_level_output_oe_out <= 1'b0;
			button_status_out_n_out <= 1'b0;
			button_status_oe_out    <= 1'b0;
			reset_out_n_out         <= 1'b0;
			reset_oe_out            <= 1'b1;
			awake_out               <= 1'b0;
			long_press_out          <= 1'b0;
			short_press_out         <= 1'b0;
		end else begin
			btn_sync                <= next_btn_sync;
			ctl_sync                <= next_ctl_sync;
			state                   <= next_state;
			timer                   <= next_timer;
			press_cnt               <= next_press_cnt;
			armed                   <= next_armed;
			btn_prev                <= next_btn_prev;
			switcher_enable_out     <= next_sw_en;
			linear_enable_out       <= next_ldo_en;
			discharge_out           <= next_discharge;
			sw0_target_mv_out       <= next_sw0_mv;
			sw1_target_mv_out       <= next_sw1_mv;
			ldo0_target_mv_out      <= next_ldo0_mv;
			ldo1_target_mv_out      <= next_ldo1_mv;
			monitor_output_out      <= next_monitor;
			aux_level_output_out    <= next_aux_level;
			aux_level_output_oe_out <= next_aux_oe;
			// Open-drain pins only ever pull low
			button_status_out_n_out <= 1'b0;
			button_status_oe_out    <= next_btn_oe;
			reset_out_n_out         <= 1'b0;
			reset_oe_out            <= next_rst_oe;
			awake_out               <= (next_state != PAC_OFF);
			long_press_out          <= next_long;
			short_press_out         <= next_short;
		end
	end

endmodule // pac_ctrl

// File: tb/pac_ctrl_chk.sv
// Concurrent checks on the ports of the PMIC control block
`timescale 1ns/1ps

module pac_ctrl_chk (
	// Clock, reset, button pin and host selects
	input wire logic       clk_in,
	input wire logic       nrst_in,
	input wire logic       button_input_n_in,
	input wire logic [3:0] discharge_select_in,
	input wire logic [2:0] monitor_select_in,
	// Observed outputs
	input wire logic [1:0] switcher_enable_out,
	input wire logic [1:0] linear_enable_out,
	input wire logic [3:0] discharge_out,
	input wire logic [4:0] monitor_output_out,
	input wire logic       aux_level_output_oe_out,
	input wire logic       button_status_out_n_out,
	input wire logic       button_status_oe_out,
	input wire logic       reset_out_n_out,
	input wire logic       reset_oe_out,
	input wire logic       awake_out,
	input wire logic       long_press_out,
	input wire logic       short_press_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_ldo_fed: assert property (
		(linear_enable_out & ~(switcher_enable_out
			& $past(switcher_enable_out))) == 2'h0)
		else $error("linear enable without its switcher");
	// Past values allow one cycle of skew around the state change
	a_off_quiet: assert property (
		!awake_out [*3] |-> $past({aux_level_output_oe_out,
			switcher_enable_out, linear_enable_out}) == 5'h00)
		else $error("output active while off");
	a_disch_sel: assert property (
		$past(nrst_in) |-> discharge_out == (~{linear_enable_out,
			switcher_enable_out} & $past(discharge_select_in)))
		else $error("discharge not tied to select and enable");
	a_button_status_out_n_on: assert property (
		!button_input_n_in [*5] |-> button_status_oe_out
			&& !button_status_out_n_out)
		else $error("button status not pulled low");
	a_button_status_out_n_off: assert property (
		button_input_n_in [*5] |-> !button_status_oe_out)
		else $error("button status low while released");
	a_wake_press: assert property (
		!awake_out && !button_input_n_in ##1 !button_input_n_in [*4]
			|-> ##[0:2] awake_out)
		else $error("press did not wake");
	a_rst_hold: assert property (
		!awake_out && !$past(awake_out) |-> reset_oe_out
			&& !reset_out_n_out)
		else $error("reset released while off");
	a_rst_late: assert property (
		$fell(reset_oe_out) |-> $past(awake_out, 8))
		else $error("reset released before sequence done");
	a_press_pulse: assert property (
		short_press_out || long_press_out |->
			!(short_press_out && long_press_out)
			##1 !(short_press_out || long_press_out))
		else $error("press pulse wrong");
	a_mon_sel: assert property (
		$past(nrst_in) |-> monitor_output_out ==
			(($past(monitor_select_in) > 3'h3) ? 5'h10
			: 5'h01 << $past(monitor_select_in)))
		else $error("monitor select wrong");
endmodule // pac_ctrl_chk

bind pac_ctrl pac_ctrl_chk u_pac_ctrl_chk (.clk_in, .nrst_in,
	.button_input_n_in, .discharge_select_in, .monitor_select_in,
	.switcher_enable_out, .linear_enable_out, .discharge_out,
	.monitor_output_out, .aux_level_output_oe_out,
	.button_status_out_n_out, .button_status_oe_out, .reset_out_n_out,
	.reset_oe_out, .awake_out, .long_press_out, .short_press_out);

// File: tb/pac_pins_model.sv
// Button and aux control pin drivers on the far side
`timescale 1ns/1ps

module pac_pins_model (
	// Requests from the bench
	input  wire logic press_in,
	input  wire logic level_in,
	input  wire logic run_in,
	// Pins
	output logic      button_n_out,
	output logic      ctl_out
);
	logic osc = 1'b0;

	// Control pin runs at 80 ns only while asked, else holds a level
	always #40 osc = run_in ? ~osc : 1'b0;
	assign button_n_out = !press_in;
	assign ctl_out = run_in ? osc : level_in;
endmodule // pac_pins_model

// File: tb/tb_pac_ctrl.sv
// Self-checking bench of the PMIC control block
`timescale 1ns/1ps

module tb_pac_ctrl;
	import pac_pkg::*;
	logic         clk_in = 1'b0, nrst_in = 1'b0;
	wire          button_input_n_in, aux_control_input_in;
	logic         press = 1'b0, ctl = 1'b0, run = 1'b0;
	logic         cap, gnd, oe, host_shutdown_in = 1'b0;
	logic [1:0]   aux_pull_mode_in = 2'h0, aux_drive_select_in = 2'h0;
	logic [5:0]   switcher_sequence_select_in = 6'h21;
	logic [5:0]   linear_sequence_select_in = 6'h13;
	logic [1:0]   switcher_host_enable_in = 2'h0, linear_host_enable_in = 2'h0;
	logic [3:0]   discharge_select_in = 4'hf;
	logic [1:0]   reset_delay_select_in = 2'h0, power_config_in = 2'h0;
	logic [2:0]   monitor_select_in = 3'h0;
	pac_code_type sw0_code_in = 6'h0, sw1_code_in = 6'h0;
	pac_code_type ldo0_code_in = 6'h0, ldo1_code_in = 6'h0;
	logic [1:0]   switcher_enable_out, linear_enable_out;
	logic [3:0]   discharge_out;
	pac_mv_type   sw0_target_mv_out, sw1_target_mv_out;
	pac_mv_type   ldo0_target_mv_out, ldo1_target_mv_out;
	logic [4:0]   monitor_output_out;
	logic         aux_level_output_out, aux_level_output_oe_out;
	logic         button_status_out_n_out, button_status_oe_out;
	logic         reset_out_n_out, reset_oe_out, awake_out;
	logic         long_press_out, short_press_out;
	int           fail_count = 0, checks = 0, k, n, held, waited;

	// Short counts keep the sequencing run between 51 and 141 cycles
	pac_ctrl #(.POR_DELAY_CYCLES(32'h14), .RST_STEP_CYCLES(32'ha),
		.LONG_PRESS_CYCLES(32'h1e)) u_pac_ctrl (.clk_in, .nrst_in,
		.button_input_n_in, .aux_control_input_in, .aux_pull_mode_in,
		.aux_drive_select_in, .switcher_sequence_select_in,
		.linear_sequence_select_in, .switcher_host_enable_in,
		.linear_host_enable_in, .discharge_select_in, .reset_delay_select_in,
		.power_config_in, .host_shutdown_in, .monitor_select_in, .sw0_code_in,
		.sw1_code_in, .ldo0_code_in, .ldo1_code_in, .switcher_enable_out,
		.linear_enable_out, .discharge_out, .sw0_target_mv_out,
		.sw1_target_mv_out, .ldo0_target_mv_out, .ldo1_target_mv_out,
		.monitor_output_out, .aux_level_output_out, .aux_level_output_oe_out,
		.button_status_out_n_out, .button_status_oe_out, .reset_out_n_out,
		.reset_oe_out, .awake_out, .long_press_out, .short_press_out);
	pac_pins_model u_pac_pins_model (.press_in(press), .level_in(ctl),
		.run_in(run), .button_n_out(button_input_n_in),
		.ctl_out(aux_control_input_in));

	initial begin
		forever #5 clk_in = ~clk_in;
	end

	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [12:0] e,
		input logic [12:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, s);
		end
	endtask

	function automatic logic hit(input int w);
		case (w)
			0: return awake_out;
			1: return !reset_oe_out;
			default: return short_press_out || long_press_out;
		endcase
	endfunction

	task automatic wait_on(input int w, input int lim);
		int i;
		for (i = 0; i < lim && hit(w) !== 1'b1; i++) @(negedge clk_in);
		waited = i;
		if (hit(w) !== 1'b1) begin
			fail_count++;
			$display("[ERR] wait %0d expected 1 seen 0", w);
			results();
		end
	endtask

	task automatic wake();
		press = 1'b1;
		wait_on(0, 12);
		chk("button_status_out_n_oe", 13'h1, 13'(button_status_oe_out));
		press = 1'b0;
		wait_on(1, 200);
		// From the entry edge: fixed delay, three reset steps, then one edge to ON
		chk("seq_len", 13'(51 + 30 * int'(reset_delay_select_in)),
			13'(waited));
		repeat (3) @(negedge clk_in);
	endtask

	initial begin
		void'($urandom(74));
		repeat (10) @(negedge clk_in);
		nrst_in = 1'b1;
		repeat (8) begin
			{sw0_code_in, sw1_code_in, ldo0_code_in} = 18'($urandom);
			ldo1_code_in = 6'($urandom);
			monitor_select_in = 3'($urandom);
			discharge_select_in = 4'($urandom);
			repeat (2) @(negedge clk_in);
			chk("sw0_mv", 13'h03e8 + 13'h0032 * 13'(sw0_code_in),
				sw0_target_mv_out);
			chk("sw1_mv", 13'h03e8 + 13'h0032 * 13'(sw1_code_in),
				sw1_target_mv_out);
			chk("ldo1_mv", 13'h01f4 + 13'h0032 * 13'(ldo1_code_in),
				ldo1_target_mv_out);
			chk("ldo0_mv", 13'h01f4 + 13'h0032 * 13'(ldo0_code_in),
				ldo0_target_mv_out);
			// Everything is off here, so every selected output discharges
			chk("disch", 13'(discharge_select_in), 13'(discharge_out));
			chk("mon", (monitor_select_in > 3'h3) ? 13'h0010
				: 13'h1 << monitor_select_in, 13'(monitor_output_out));
		end
		ldo0_code_in = 6'h3f;
		repeat (2) @(negedge clk_in);
		chk("ldo0_max", 13'h0e42, ldo0_target_mv_out);
		chk("awake", 13'h0, 13'(awake_out));
		wake();
		chk("sw_en", 13'h3, 13'(switcher_enable_out));
		chk("ldo_en", 13'h3, 13'(linear_enable_out));
		chk("disch_on", 13'h0, 13'(discharge_out));
		linear_sequence_select_in[2:0] = 3'h0;
		repeat (3) @(negedge clk_in);
		chk("ldo0_host_off", 13'h0, 13'(linear_enable_out[0]));
		linear_host_enable_in = 2'h1;
		repeat (3) @(negedge clk_in);
		chk("ldo0_host_on", 13'h1, 13'(linear_enable_out[0]));
		for (k = 0; k < 4; k++) begin
			linear_sequence_select_in[5:3] = k[1] ? 3'h6 : 3'h5;
			ctl = k[0];
			repeat (6) @(negedge clk_in);
			chk("ldo1_ctl", 13'(k[1] == k[0]), 13'(linear_enable_out[1]));
		end
		for (k = 0; k < 64; k++) begin
			{cap, aux_pull_mode_in, aux_drive_select_in, ctl} = 6'(k);
			linear_sequence_select_in[5:3] = cap ? 3'h6 : 3'h2;
			repeat (5) @(negedge clk_in);
			gnd = (cap & aux_drive_select_in[1]) ? ctl ^ aux_drive_select_in[0]
				: !aux_drive_select_in[0];
			oe = gnd ? aux_pull_mode_in[1] : aux_pull_mode_in[0];
			chk("aux_oe", 13'(oe), 13'(aux_level_output_oe_out));
			if (oe) begin
				chk("aux_lvl", 13'(gnd), 13'(aux_level_output_out));
			end
		end
		aux_drive_select_in = 2'h2;
		run = 1'b1;
		n = 0;
		repeat (40) begin
			gnd = aux_level_output_out;
			@(negedge clk_in);
			n += (gnd !== aux_level_output_out);
		end
		run = 1'b0;
		chk("aux_toggles", 13'h1, 13'(n > 4));
		for (k = 0; k < 3; k++) begin
			held = (k == 0) ? 5 : 40;
			power_config_in = (k == 1) ? 2'h0 : 2'h1;
			press = 1'b1;
			repeat (held) @(negedge clk_in);
			press = 1'b0;
			wait_on(2, 12);
			chk("long", 13'(held >= 30), 13'(long_press_out));
			chk("short", 13'(held < 30), 13'(short_press_out));
			repeat (3) @(negedge clk_in);
			chk("awake", 13'(k < 2), 13'(awake_out));
		end
		reset_delay_select_in = 2'($urandom);
		wake();
		host_shutdown_in = 1'b1;
		repeat (4) @(negedge clk_in);
		host_shutdown_in = 1'b0;
		chk("off_en", 13'h0, 13'({switcher_enable_out,
			linear_enable_out, awake_out}));
		results();
	end
endmodule // tb_pac_ctrl
